// file: cmdd_arb_model.sv
// Arbiter model on the far side of the decoder's off-board request.
// Assumes a low-active request that stands for the whole off-board cycle.
`timescale 1ns/1ps
module cmdd_arb (
    // Clock, reset and pace
    input wire clock, resetn, slow,
    // Request in, grants out, low active
    input wire offboard_bus_request,
    output reg offboard_address_enable, command_enable_in
);
    reg [2:0] wait_cnt;
    // Grants come only after the wait for the bus; slow mode shows a busy bus
    always @(posedge clock) begin
        if (!resetn || offboard_bus_request) begin
            wait_cnt <= 3'h0;
            {offboard_address_enable, command_enable_in} <= #1 2'h3;
        end else begin
            wait_cnt <= wait_cnt + {2'h0, wait_cnt != 3'h7};
            if (wait_cnt >= (slow ? 3'h4 : 3'h1))
                {offboard_address_enable, command_enable_in} <= #1 2'h0;
        end
    end
endmodule

// file: cmdd_cell.v
// Active-low command decoder cell, built from OR terms.
// Assumes all inputs are already synchronised to the caller's clock.
`timescale 1ns/1ps
`include "cmdd_map.vh"

module cmdd_cell (
    // Qualifiers
    input wire mem_not_io_select,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire irq_ack_strobe_in,
    input wire command_enable_in,
    input wire output_float_enable,
    // Decoded commands, low active, with float control
    output wire mem_read_cmd,
    output wire mem_write_cmd,
    output wire io_read_cmd,
    output wire io_write_cmd,
    output wire irq_ack_cmd,
    output wire cmd_float_n
);

// ****************************************
// OR-gate decode
// ****************************************
// Any high OR term forces the output inactive high
assign mem_read_cmd = ~mem_not_io_select | read_strobe_n | command_enable_in;
assign mem_write_cmd = ~mem_not_io_select | write_strobe_n | command_enable_in;
assign io_read_cmd = mem_not_io_select | read_strobe_n | command_enable_in;
assign io_write_cmd = mem_not_io_select | write_strobe_n | command_enable_in;
assign irq_ack_cmd = irq_ack_strobe_in;
// Address enable alone decides driving versus floating
assign cmd_float_n = output_float_enable;

endmodule

// file: cmdd_decoder.v
// Bus command decoder: on-board active-high and off-board active-low copies.
// Assumes processor strobes and arbiter grants arrive asynchronously.
// Operation
// - Lower memory half off-board, upper on-board
// - Ports F000-FFFF on-board, rest off-board
// - Only on-board active-high interrupt acknowledge
// - On-board commands always driven, never floating
// - Off-board commands float outside off-board cycles
// - Request bus for off-board read or write
// - Command enable gates; address enable floats
// - Decoder cell is OR logic
// - On-board copy uses inverted outputs
// - Memory read needs select high, read and enable low
// - I/O read needs select, read, enable low
// - I/O write needs select, write, enable low
// - Acknowledge follows strobe, always driven, never floats
// - On-board enable qualifies; its float disabled
`timescale 1ns/1ps
`include "cmdd_map.vh"

module cmdd_decoder (
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Processor strobes, low active except select and acknowledge
    input wire mem_not_io_select,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire irq_ack_strobe_in,
    input wire [19:0] cpu_address,
    // Arbiter grants, low active
    input wire command_enable_in,
    input wire offboard_address_enable,
    // Arbiter request, low active, output enable low while driven
    output reg offboard_bus_request,
    output wire offboard_bus_request_oe_n,
    // On-board commands, high active, always driven
    output reg onb_mem_read_cmd,
    output reg onb_mem_write_cmd,
    output reg onb_io_read_cmd,
    output reg onb_io_write_cmd,
    output reg irq_ack_cmd,
    // Off-board commands, low active, three-state
    output reg offb_mem_read_cmd,
    output reg offb_mem_write_cmd,
    output reg offb_io_read_cmd,
    output reg offb_io_write_cmd,
    output reg offb_cmd_oe_n
);

// ****************************************
// Input synchronisers
// ****************************************
// Stage one of each synchroniser; nothing but stage two reads these
reg mio_a;
reg rd_n_a;
reg wr_n_a;
reg irq_ack_cmd_a;
reg command_enable_in_n_a;
reg aen_n_a;
reg [19:0] addr_a;
// Stage two; the decode logic reads only these
reg s_mio;
reg s_rd_n;
reg s_wr_n;
reg s_irq_ack_cmd;
reg s_command_enable_in_n;
reg s_aen_n;
reg [19:0] s_addr;

// Memory or I/O select; idles as a memory cycle
always @(posedge clock) begin
    if (!resetn) begin
        mio_a <= `CMDD_SEL_MEM;
        s_mio <= `CMDD_SEL_MEM;
    end else begin
        mio_a <= mem_not_io_select;
        s_mio <= mio_a;
    end
end

// Read strobe; idles inactive high so no command leaks out of reset
always @(posedge clock) begin
    if (!resetn) begin
        rd_n_a <= `CMDD_INACTIVE_HI;
        s_rd_n <= `CMDD_INACTIVE_HI;
    end else begin
        rd_n_a <= read_strobe_n;
        s_rd_n <= rd_n_a;
    end
end

// Write strobe; idles inactive high
always @(posedge clock) begin
    if (!resetn) begin
        wr_n_a <= `CMDD_INACTIVE_HI;
        s_wr_n <= `CMDD_INACTIVE_HI;
    end else begin
        wr_n_a <= write_strobe_n;
        s_wr_n <= wr_n_a;
    end
end

// Acknowledge strobe; idles low so no false acknowledge follows reset
always @(posedge clock) begin
    if (!resetn) begin
        irq_ack_cmd_a <= `CMDD_ACK_IDLE;
        s_irq_ack_cmd <= `CMDD_ACK_IDLE;
    end else begin
        irq_ack_cmd_a <= irq_ack_strobe_in;
        s_irq_ack_cmd <= irq_ack_cmd_a;
    end
end

// Command enable from the arbiter; idles withheld
always @(posedge clock) begin
    if (!resetn) begin
        command_enable_in_n_a <= `CMDD_INACTIVE_HI;
        s_command_enable_in_n <= `CMDD_INACTIVE_HI;
    end else begin
        command_enable_in_n_a <= command_enable_in;
        s_command_enable_in_n <= command_enable_in_n_a;
    end
end

// Address enable from the arbiter; idles floating
always @(posedge clock) begin
    if (!resetn) begin
        aen_n_a <= `CMDD_FLOAT_OE_N;
        s_aen_n <= `CMDD_FLOAT_OE_N;
    end else begin
        aen_n_a <= offboard_address_enable;
        s_aen_n <= aen_n_a;
    end
end

// Address; bits may skew while it settles, but the strobes come later anyway
always @(posedge clock) begin
    if (!resetn) begin
        addr_a <= `CMDD_ADDR_IDLE;
        s_addr <= `CMDD_ADDR_IDLE;
    end else begin
        addr_a <= cpu_address;
        s_addr <= addr_a;
    end
end

// ****************************************
// Target decode
// ****************************************
// Memory half split on the top address bit, I/O on the top nibble
wire upper_mem = s_addr[`CMDD_MEM_SPLIT_BIT];
wire top_ports = (s_addr[`CMDD_IO_TOP_MSB:`CMDD_IO_TOP_LSB] == `CMDD_IO_TOP_NIBBLE);
wire is_mem = (s_mio == `CMDD_SEL_MEM);
wire cycle_any = ~s_rd_n | ~s_wr_n;
wire onboard_target = is_mem ? upper_mem : top_ports;
wire offboard_select_term = cycle_any & ~onboard_target;
// Low active enable, as the cell expects
wire onboard_decoder_enable = ~onboard_target;

// ****************************************
// Decoder cells
// ****************************************
wire off_mrd;
wire off_mwt;
wire off_ior;
wire off_iow;
wire off_float_n;
wire on_mrd;
wire on_mwt;
wire on_ior;
wire on_iow;
wire on_irq_ack_cmd;

// Off-board copy: no acknowledge, floats under the arbiter's address enable
cmdd_cell off_cell (
    .mem_not_io_select(s_mio),
    .read_strobe_n(s_rd_n),
    .write_strobe_n(s_wr_n),
    .irq_ack_strobe_in(`CMDD_INACTIVE_HI),
    .command_enable_in(s_command_enable_in_n),
    .output_float_enable(s_aen_n),
    .mem_read_cmd(off_mrd),
    .mem_write_cmd(off_mwt),
    .io_read_cmd(off_ior),
    .io_write_cmd(off_iow),
    .irq_ack_cmd(),
    .cmd_float_n(off_float_n)
);

// On-board copy: same cell, outputs inverted to high active; ack enters inverted
cmdd_cell on_cell (
    .mem_not_io_select(s_mio),
    .read_strobe_n(s_rd_n),
    .write_strobe_n(s_wr_n),
    .irq_ack_strobe_in(~s_irq_ack_cmd),
    .command_enable_in(onboard_decoder_enable),
    .output_float_enable(`CMDD_DRIVE_OE_N),
    .mem_read_cmd(on_mrd),
    .mem_write_cmd(on_mwt),
    .io_read_cmd(on_ior),
    .io_write_cmd(on_iow),
    .irq_ack_cmd(on_irq_ack_cmd),
    .cmd_float_n()
);

// ****************************************
// Output registers
// ****************************************
// On-board memory read; held at a level through reset too, never floating
always @(posedge clock) begin
    if (!resetn) begin
        onb_mem_read_cmd <= `CMDD_ONB_IDLE;
    end else begin
        onb_mem_read_cmd <= ~on_mrd;
    end
end

// On-board memory write; the enable already limits it to the upper half
always @(posedge clock) begin
    if (!resetn) begin
        onb_mem_write_cmd <= `CMDD_ONB_IDLE;
    end else begin
        onb_mem_write_cmd <= ~on_mwt;
    end
end

// On-board port read, top port range only
always @(posedge clock) begin
    if (!resetn) begin
        onb_io_read_cmd <= `CMDD_ONB_IDLE;
    end else begin
        onb_io_read_cmd <= ~on_ior;
    end
end

// On-board port write, top port range only
always @(posedge clock) begin
    if (!resetn) begin
        onb_io_write_cmd <= `CMDD_ONB_IDLE;
    end else begin
        onb_io_write_cmd <= ~on_iow;
    end
end

// Acknowledge, on-board only; the cell's inversion is undone here
always @(posedge clock) begin
    if (!resetn) begin
        irq_ack_cmd <= `CMDD_ACK_IDLE;
    end else begin
        irq_ack_cmd <= ~on_irq_ack_cmd;
    end
end

// Off-board memory read; qualified only by the arbiter's command enable
always @(posedge clock) begin
    if (!resetn) begin
        offb_mem_read_cmd <= `CMDD_INACTIVE_HI;
    end else begin
        offb_mem_read_cmd <= off_mrd;
    end
end

// Off-board memory write
always @(posedge clock) begin
    if (!resetn) begin
        offb_mem_write_cmd <= `CMDD_INACTIVE_HI;
    end else begin
        offb_mem_write_cmd <= off_mwt;
    end
end

// Off-board port read
always @(posedge clock) begin
    if (!resetn) begin
        offb_io_read_cmd <= `CMDD_INACTIVE_HI;
    end else begin
        offb_io_read_cmd <= off_ior;
    end
end

// Off-board port write
always @(posedge clock) begin
    if (!resetn) begin
        offb_io_write_cmd <= `CMDD_INACTIVE_HI;
    end else begin
        offb_io_write_cmd <= off_iow;
    end
end

// Off-board float control; grants only come once the arbiter owns the bus
always @(posedge clock) begin
    if (!resetn) begin
        offb_cmd_oe_n <= `CMDD_FLOAT_OE_N;
    end else begin
        offb_cmd_oe_n <= off_float_n;
    end
end

// Bus request; registered so a settling address cannot glitch the arbiter
always @(posedge clock) begin
    if (!resetn) begin
        offboard_bus_request <= `CMDD_INACTIVE_HI;
    end else begin
        offboard_bus_request <= ~offboard_select_term;
    end
end

// Request line is always driven
assign offboard_bus_request_oe_n = `CMDD_DRIVE_OE_N;

endmodule

// file: cmdd_decoder_assertions.sv
// Checker for the bus command decoder: each output against its inputs.
// Assumes three edges from an input change to the output that follows it.
`timescale 1ns/1ps
module cmdd_chk (
    // Decoder ports
    input wire clock, resetn, mem_not_io_select, read_strobe_n, write_strobe_n,
    input wire irq_ack_strobe_in, command_enable_in, offboard_address_enable,
    input wire [19:0] cpu_address,
    input wire offboard_bus_request, offboard_bus_request_oe_n, offb_cmd_oe_n, irq_ack_cmd,
    input wire onb_mem_read_cmd, onb_mem_write_cmd, onb_io_read_cmd, onb_io_write_cmd,
    input wire offb_mem_read_cmd, offb_mem_write_cmd, offb_io_read_cmd, offb_io_write_cmd
);
    reg [1:0] age;
    wire m = mem_not_io_select;
    wire up = cpu_address[19];
    wire top = &cpu_address[15:12];
    wire off = (m ? !up : !top) & !(read_strobe_n & write_strobe_n);
    // Pipeline holds reset values for three edges, so checks wait that long
    always @(posedge clock) begin
        if (!resetn)
            age <= 2'h0;
        else if (age != 2'h3)
            age <= age + 2'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn || age != 2'h3);
    chk_onb_mem_read: assert property (onb_mem_read_cmd == $past(m & up & !read_strobe_n, 3))
        else $error("on-board memory read wrong");
    chk_onb_mem_write: assert property (onb_mem_write_cmd == $past(m & up & !write_strobe_n, 3))
        else $error("on-board memory write wrong");
    chk_onb_io_pair: assert property ({onb_io_read_cmd, onb_io_write_cmd} ==
        $past({!m & top & !read_strobe_n, !m & top & !write_strobe_n}, 3)) else $error("on-board io wrong");
    chk_ack_follows: assert property (irq_ack_cmd == $past(irq_ack_strobe_in, 3))
        else $error("acknowledge wrong");
    chk_bus_request: assert property (offboard_bus_request == $past(!off, 3))
        else $error("bus request wrong");
    chk_offb_float: assert property (offb_cmd_oe_n == $past(offboard_address_enable, 3))
        else $error("off-board float wrong");
    chk_offb_mem_cmds: assert property ({offb_mem_read_cmd, offb_mem_write_cmd} ==
        $past({!m | read_strobe_n, !m | write_strobe_n} | {2{command_enable_in}}, 3))
        else $error("off-board memory command wrong");
    chk_offb_io_cmds: assert property ({offb_io_read_cmd, offb_io_write_cmd} ==
        $past({m | read_strobe_n, m | write_strobe_n} | {2{command_enable_in}}, 3))
        else $error("off-board io command wrong");
    chk_req_driven: assert property (offboard_bus_request_oe_n == 1'b0)
        else $error("request line not driven");
    cover property (onb_mem_read_cmd);
    cover property (!offb_cmd_oe_n && !offb_io_write_cmd);
    cover property (irq_ack_cmd);
endmodule
bind cmdd_decoder cmdd_chk u_cmdd_chk (.*);

// file: cmdd_map.vh
// Constants for the bus command decoder: strobe levels, address
// decode boundaries and pin enable levels.
// Assumes a 20-bit memory address and a 16-bit I/O port address.
`ifndef CMDD_MAP_VH
`define CMDD_MAP_VH

// ****************************************
// Address decode
// ****************************************
`define CMDD_MEM_SPLIT_BIT 19
`define CMDD_IO_TOP_MSB 15
`define CMDD_IO_TOP_LSB 12
`define CMDD_IO_TOP_NIBBLE 4'hf

// ****************************************
// Levels
// ****************************************
`define CMDD_SEL_MEM 1'b1
`define CMDD_INACTIVE_HI 1'b1
`define CMDD_DRIVE_OE_N 1'b0
`define CMDD_FLOAT_OE_N 1'b1
`define CMDD_ONB_IDLE 1'b0
`define CMDD_ACK_IDLE 1'b0
`define CMDD_ADDR_IDLE 20'h00000

`endif

// file: tb.sv
// Testbench for the bus command decoder with an arbiter model.
// Assumes three edges of latency; stimulus lands 1 ns after each edge.
`timescale 1ns/1ps
module tb;
    reg clock, resetn, sel_mem, rd_n, wr_n, ack, slow;
    reg [19:0] addr;
    wire req_n, adr_en_n, cmd_en_n;
    wire [10:0] obs;
    integer err_total, samples_checked, cycles;
    cmdd_decoder u_cmdd_decoder (.clock(clock), .resetn(resetn), .mem_not_io_select(sel_mem),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .irq_ack_strobe_in(ack), .cpu_address(addr),
        .command_enable_in(cmd_en_n), .offboard_address_enable(adr_en_n),
        .offboard_bus_request(req_n), .offboard_bus_request_oe_n(), .onb_mem_read_cmd(obs[10]),
        .onb_mem_write_cmd(obs[9]), .onb_io_read_cmd(obs[8]), .onb_io_write_cmd(obs[7]),
        .irq_ack_cmd(obs[6]), .offb_cmd_oe_n(obs[4]), .offb_mem_read_cmd(obs[3]),
        .offb_mem_write_cmd(obs[2]), .offb_io_read_cmd(obs[1]), .offb_io_write_cmd(obs[0]));
    assign obs[5] = req_n;
    cmdd_arb u_cmdd_arb (.clock(clock), .resetn(resetn), .slow(slow),
        .offboard_bus_request(req_n), .offboard_address_enable(adr_en_n),
        .command_enable_in(cmd_en_n));
    // Expected outputs from strobes {select, read, write, ack}, address and grant
    function [10:0] ev(input [3:0] c, input [19:0] a, input g);
        reg up, top, off;
        begin
            up = a[19];
            top = &a[15:12];
            off = (c[3] ? !up : !top) & !(c[2] & c[1]);
            ev = {c[3] & up & !c[2], c[3] & up & !c[1], !c[3] & top & !c[2], !c[3] & top & !c[1],
                c[0], !off, !g, !c[3] | c[2] | !g, !c[3] | c[1] | !g, c[3] | c[2] | !g, c[3] | c[1] | !g};
        end
    endfunction
    task step(input [3:0] c, input [19:0] a, input integer n, input g);
        reg [10:0] e;
        begin
            @(posedge clock);
            #1;
            {sel_mem, rd_n, wr_n, ack, addr} = {c, a};
            repeat (n) @(posedge clock);
            #1;
            e = ev(c, a, g);
            samples_checked = samples_checked + 1;
            if (obs !== e) begin
                err_total = err_total + 1;
                $display("[ERR] outputs exp %h got %h", e, obs);
            end
        end
    endtask
    task end_of_test;
        begin
            if (err_total == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // ***
    // Scenarios: boundaries of both address splits, slow and prompt grants
    // ***
    task t_onboard;
        begin
            step(4'ha, 20'h80000, 4, 1'h0);
            step(4'hc, 20'hfffff, 4, 1'h0);
            step(4'h2, 20'h0f000, 4, 1'h0);
            step(4'h4, 20'h0ffff, 4, 1'h0);
            step(4'h7, 20'h00000, 4, 1'h0);
        end
    endtask
    task t_offboard;
        begin
            slow = 1'h1;
            step(4'ha, 20'h7ffff, 4, 1'h0);
            step(4'ha, 20'h7ffff, 12, 1'h1);
            step(4'he, 20'h7ffff, 10, 1'h0);
        end
    endtask
    task t_prompt;
        begin
            slow = 1'h0;
            step(4'h4, 20'h0efff, 10, 1'h1);
            step(4'h2, 20'h00000, 4, 1'h1);
            step(4'hc, 20'h00000, 4, 1'h1);
            step(4'h7, 20'h00000, 8, 1'h0);
        end
    endtask
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    initial begin
        {err_total, samples_checked, cycles} = {32'h0, 32'h0, 32'h0};
        {resetn, sel_mem, rd_n, wr_n, ack, addr, slow} = {1'h0, 4'he, 20'h00000, 1'h0};
        repeat (4) @(posedge clock);
        #1;
        resetn = 1'h1;
        t_onboard;
        t_offboard;
        t_prompt;
        end_of_test;
    end
endmodule
